// [hw/pps_pkg.sv]
// Purpose: Shared constants for the port power source select register bank
// Assumes: 32-bit APB data, byte addresses, three downstream ports (2..4)
// Notes: Each config register is 8 bits wide in the low byte of a word
package pps_pkg;
    // Port count and register byte addresses
    localparam int NUM_PORTS = 3;
    localparam logic [15:0] PORT2_CFG_ADDR = 16'h3c04;
    localparam logic [15:0] PORT3_CFG_ADDR = 16'h3c08;
    localparam logic [15:0] PORT4_CFG_ADDR = 16'h3c0c;
    localparam logic [15:0] PORT_CFG_STRIDE = 16'h0004;
    // Field positions inside a config byte
    localparam int COMBINED_BIT = 7;
    localparam int RESERVED_BIT = 6;
    localparam int DISABLE_BIT = 5;
    localparam int FIXED_BIT = 4;
    localparam int CODE_MSB = 3;
    localparam int CODE_LSB = 0;
    // Writable bits: everything but the reserved bit
    localparam logic [7:0] CFG_WR_MASK = 8'hbf;
    // Reset value of every config register
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Power source codes
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_USB2 = 4'h1;
    localparam logic [3:0] SRC_USB3 = 4'h2;
    localparam logic [3:0] SRC_EITHER = 4'h3;
    localparam logic [3:0] SRC_GPIO = 4'h4;
endpackage : pps_pkg

// [hw/pps_gate_if.sv]
// Purpose: Carries one port's source code and power inputs to its gate
// Assumes: Single clock domain, purely combinational path
// Notes: ctrl side drives selection, gate side returns the power decision
`timescale 1ns/100ps
`default_nettype none
interface pps_gate_if;
    logic [3:0] power_source_code; // Selected source
    logic port_disable; // Port disable bit
    logic usb2_on; // USB2 port power request
    logic usb3_on; // USB3 port power request
    logic gpio_on; // Designated GPIO, already synchronised
    logic power_on; // Resulting power decision
    modport ctrl (output power_source_code, port_disable, usb2_on, usb3_on, gpio_on, input power_on);
    modport gate (input power_source_code, port_disable, usb2_on, usb3_on, gpio_on, output power_on);
endinterface : pps_gate_if
`default_nettype wire

// [hw/pps_port_gate.sv]
// Purpose: Selects the source that switches one port's power
// Assumes: Inputs already in the pclk domain
// Notes: Combinational; the top module registers the result
`timescale 1ns/100ps
`default_nettype none
module pps_port_gate (
    // Selection and sources
    pps_gate_if.gate gif
);
    // Source multiplexer, forced off by the disable bit
    always_comb
    begin
        gif.power_on = 1'b0;
        if (!gif.port_disable)
        begin
            case (gif.power_source_code)
                pps_pkg::SRC_OFF: gif.power_on = 1'b0;
                pps_pkg::SRC_USB2: gif.power_on = gif.usb2_on;
                pps_pkg::SRC_USB3: gif.power_on = gif.usb3_on;
                pps_pkg::SRC_EITHER: gif.power_on = gif.usb2_on | gif.usb3_on;
                pps_pkg::SRC_GPIO: gif.power_on = gif.gpio_on;
                // Reserved codes keep power off, the safe choice
                default: gif.power_on = 1'b0;
            endcase
        end
    end
endmodule : pps_port_gate
`default_nettype wire

// [hw/pps_top.sv]
// Purpose: APB register bank selecting the power source of ports 2..4
// Assumes: pclk at 10 MHz, presetn asynchronous active low
// Notes: Zero wait-state APB slave; outputs all come from flip-flops
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module pps_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power sources, index 0 is port 2
    input wire logic [2:0] usb2_port_power,
    input wire logic [2:0] usb3_port_power,
    input wire logic [2:0] gpio_port_power,
    // Per-port results
    output logic [2:0] port_power_on,
    output logic [2:0] port_disabled,
    output logic [2:0] fixed_attached_device,
    output logic [2:0] combined_pin_mode
);
    // Config registers, index 0 is port 2
    logic [7:0] cfg_r [3];
    // GPIO synchroniser stages
    logic [2:0] gpio_s1_r;
    logic [2:0] gpio_s2_r;
    // Gate results
    logic [2:0] gate_power;
    // Raw decode result: bit 2 is the hit, bits 1:0 the port index
    logic [2:0] dec;
    // Decoded register hit
    logic hit;
    logic [1:0] idx;

    // Maps a byte address onto a port index, or flags a miss
    function automatic logic [2:0] cfg_decode(input logic [15:0] a);
        logic [2:0] r;
        r = 3'h0;
        if (a == pps_pkg::PORT2_CFG_ADDR)
            r = 3'h4;
        else if (a == pps_pkg::PORT3_CFG_ADDR)
            r = 3'h5;
        else if (a == pps_pkg::PORT4_CFG_ADDR)
            r = 3'h6;
        return r;
    endfunction : cfg_decode

    // Hit flag and index from the current address
    assign dec = cfg_decode(paddr);
    assign hit = dec[2];
    assign idx = dec[1:0];

    // APB handshake: ready is raised in setup so access ends at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (pclk_en)
        begin
            pready <= psel && !penable;
            // Unmapped addresses answer with an error and zero data
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && hit && !pwrite)
                prdata <= {24'h00_0000, cfg_r[idx] & pps_pkg::CFG_WR_MASK};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // Register writes on the completing access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < pps_pkg::NUM_PORTS; i++)
                cfg_r[i] <= pps_pkg::CFG_RESET;
        end
        else if (pclk_en && psel && penable && pready && pwrite && hit)
        begin
            // Reserved bit stays zero whatever is written
            cfg_r[idx] <= pwdata[7:0] & pps_pkg::CFG_WR_MASK;
        end
    end

    // GPIO arrives from pins, two flops before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gpio_s1_r <= 3'h0;
            gpio_s2_r <= 3'h0;
        end
        else if (pclk_en)
        begin
            gpio_s1_r <= gpio_port_power;
            gpio_s2_r <= gpio_s1_r;
        end
    end

    // One gate per port
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_port
            pps_gate_if gif ();
            assign gif.power_source_code = cfg_r[g][pps_pkg::CODE_MSB:pps_pkg::CODE_LSB];
            assign gif.port_disable = cfg_r[g][pps_pkg::DISABLE_BIT];
            assign gif.usb2_on = usb2_port_power[g];
            assign gif.usb3_on = usb3_port_power[g];
            assign gif.gpio_on = gpio_s2_r[g];
            assign gate_power[g] = gif.power_on;
            pps_port_gate u_gate (
                .gif(gif.gate)
            );
        end
    endgenerate

    // Registered per-port outputs, recomputed every enabled cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_power_on <= 3'h0;
            port_disabled <= 3'h0;
            fixed_attached_device <= 3'h0;
            combined_pin_mode <= 3'h0;
        end
        else if (pclk_en)
        begin
            port_power_on <= gate_power;
            for (int i = 0; i < pps_pkg::NUM_PORTS; i++)
            begin
                port_disabled[i] <= cfg_r[i][pps_pkg::DISABLE_BIT];
                fixed_attached_device[i] <= cfg_r[i][pps_pkg::FIXED_BIT];
                combined_pin_mode[i] <= cfg_r[i][pps_pkg::COMBINED_BIT];
            end
        end
    end

    // Checks on the outputs and config registers; all sample on pclk and rest during reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Setup of any transfer is answered in the very next cycle
    ready_setup_a: assert property (pclk_en && psel && !penable |=> pready)
        else $error("no ready after setup");
    // Unmapped addresses answer with an error and zero data
    err_unmapped_a: assert property (pclk_en && psel && !penable && !hit |=>
        pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    // Read data carries the addressed register, bit 6 clear, no error
    rd_data_a: assert property (pclk_en && psel && !penable && hit && !pwrite |=>
        prdata[7:0] == ($past(cfg_r[idx]) & pps_pkg::CFG_WR_MASK) && !pslverr)
        else $error("read data differs from register");
    // Reserved bit 6 and the upper bytes always read as zero
    rsvd_zero_a: assert property (pready && !pslverr && $past(pclk_en) |->
        prdata[31:8] == 24'h00_0000 && !prdata[pps_pkg::RESERVED_BIT])
        else $error("reserved read bits not zero");
    // A completed write to port 3 lands with the reserved bit cleared
    write_store_a: assert property (pclk_en && psel && penable && pready && pwrite
        && paddr == pps_pkg::PORT3_CFG_ADDR
        |=> cfg_r[1] == ($past(pwdata[7:0]) & pps_pkg::CFG_WR_MASK))
        else $error("write to port 3 register not stored");

    // Port 2 never shows power while its disable bit is set
    pwr_disable_off_a: assert property ($past(pclk_en) && $past(cfg_r[0][5]) |-> !port_power_on[0])
        else $error("port 2 powered while disabled");
    // The disable bit wins on every port, whatever the source code
    pwr_dis_all_a: assert property ($past(pclk_en) |->
        (port_power_on & {$past(cfg_r[2][pps_pkg::DISABLE_BIT]),
        $past(cfg_r[1][pps_pkg::DISABLE_BIT]),
        $past(cfg_r[0][pps_pkg::DISABLE_BIT])}) == 3'h0)
        else $error("disabled port powered");
    // Source code off keeps port 3 dark
    pwr_code_off_a: assert property ($past(pclk_en) && $past(cfg_r[1][3:0]) == pps_pkg::SRC_OFF
        |-> !port_power_on[1])
        else $error("port 3 powered with source off");
    // Port 2 on the USB2 source tracks last cycle's request
    pwr_usb2_a: assert property ($past(pclk_en) && $past(cfg_r[0][3:0]) == pps_pkg::SRC_USB2
        && !$past(cfg_r[0][pps_pkg::DISABLE_BIT]) |-> port_power_on[0] == $past(usb2_port_power[0]))
        else $error("port 2 not following usb2 power");
    // Port 3 on the USB3 source tracks last cycle's request
    pwr_usb3_a: assert property ($past(pclk_en) && $past(cfg_r[1][3:0]) == pps_pkg::SRC_USB3
        && !$past(cfg_r[1][pps_pkg::DISABLE_BIT]) |-> port_power_on[1] == $past(usb3_port_power[1]))
        else $error("port 3 not following usb3 power");
    // Port 4 on either source powers up when one of them is on
    pwr_either_a: assert property ($past(pclk_en) && $past(cfg_r[2][3:0]) == pps_pkg::SRC_EITHER
        && !$past(cfg_r[2][pps_pkg::DISABLE_BIT])
        |-> port_power_on[2] == ($past(usb2_port_power[2]) | $past(usb3_port_power[2])))
        else $error("port 4 not following either source");
    // GPIO path: two sync flops plus the output flop, three enabled edges
    pwr_gpio_a: assert property ($past(pclk_en) && $past(pclk_en, 2) && $past(pclk_en, 3)
        && $past(cfg_r[0][3:0]) == pps_pkg::SRC_GPIO && !$past(cfg_r[0][pps_pkg::DISABLE_BIT])
        |-> port_power_on[0] == $past(gpio_port_power[0], 3))
        else $error("port 2 not following gpio after sync");

    // Shared-pin flags copy bit 7 of each register, one edge later
    mode_bits_a: assert property ($past(pclk_en) |->
        combined_pin_mode == {$past(cfg_r[2][pps_pkg::COMBINED_BIT]),
        $past(cfg_r[1][pps_pkg::COMBINED_BIT]), $past(cfg_r[0][pps_pkg::COMBINED_BIT])})
        else $error("shared-pin outputs disagree with registers");
    // Disabled and fixed-device flags copy bits 5 and 4, one edge later
    port_flags_a: assert property ($past(pclk_en) |->
        port_disabled == {$past(cfg_r[2][pps_pkg::DISABLE_BIT]),
        $past(cfg_r[1][pps_pkg::DISABLE_BIT]), $past(cfg_r[0][pps_pkg::DISABLE_BIT])}
        && fixed_attached_device == {$past(cfg_r[2][pps_pkg::FIXED_BIT]),
        $past(cfg_r[1][pps_pkg::FIXED_BIT]), $past(cfg_r[0][pps_pkg::FIXED_BIT])})
        else $error("flag outputs disagree with registers");
endmodule : pps_top
`default_nettype wire

// [sim/tb_port_power_source_select.sv]
// Purpose: Self-checking bench for the port power source select bank
// Assumes: APB slave with at most 20 wait states, pclk_en high except in the freeze test
// Notes: Expected values come from the field layout, never the design
`timescale 1ns/100ps
`default_nettype none
module tb_port_power_source_select;
    // Clock, reset and APB master side
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Power sources and per-port results
    logic [2:0] usb2 = 3'h0;
    logic [2:0] usb3 = 3'h0;
    logic [2:0] gpio = 3'h0;
    logic en = 1'b1; // Clock enable into the design
    logic [2:0] pwr_on;
    logic [2:0] dis;
    logic [2:0] fixed;
    logic [2:0] comb;
    // Bench state
    int n_fail = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic err;
    logic [2:0] sv;
    logic [7:0] cfg [3];
    logic [15:0] addr [3] = '{pps_pkg::PORT2_CFG_ADDR, pps_pkg::PORT3_CFG_ADDR, pps_pkg::PORT4_CFG_ADDR};

    // 100 ns period
    always #50 pclk = ~pclk;

    pps_top DUT (.pclk(pclk), .presetn(presetn), .pclk_en(en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .usb2_port_power(usb2), .usb3_port_power(usb3), .gpio_port_power(gpio),
        .port_power_on(pwr_on), .port_disabled(dis), .fixed_attached_device(fixed),
        .combined_pin_mode(comb));

    // Verdict and end of run
    task results;
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // Compare one value
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; pready is judged at the rising edge that ends the access
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                n_fail++;
                results();
            end
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Power expected from a config byte and the three sources
    function automatic logic pwr_exp(input logic [7:0] c, input logic u2, input logic u3, input logic g);
        if (c[5])
            return 1'b0;
        case (c[3:0])
            4'h1: return u2;
            4'h2: return u3;
            4'h3: return u2 | u3;
            4'h4: return g;
            default: return 1'b0;
        endcase
    endfunction : pwr_exp

    // Main sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, addr[i], 32'h00000000);
            chk("reset value", rd, 32'h00000000);
            chk("mapped read error flag", {31'h0, err}, 32'h00000000);
            apb(1'b1, addr[i], 32'hffffffff);
            apb(1'b0, addr[i], 32'h00000000);
            chk("bit 6 read-only", rd, 32'h000000bf);
        end
        $display("Test register access done");
        // Unmapped word: error answer, registers untouched
        apb(1'b1, 16'h3c10, 32'h00000005);
        chk("unmapped write error", {31'h0, err}, 32'h00000001);
        apb(1'b0, 16'h3c10, 32'h00000000);
        chk("unmapped read data", rd, 32'h00000000);
        apb(1'b0, addr[0], 32'h00000000);
        chk("port2 after unmapped", rd, 32'h000000bf);
        $display("Test unmapped access done");
        // Every source code, with mode bits varied per port
        for (int code = 0; code < 5; code++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                cfg[i] = {i == 2 ^ code[1], 1'b0, code == i + 2, i == 1 ^ code[0], code[3:0]};
                apb(1'b1, addr[i], {24'h000000, cfg[i]});
            end
            for (int s = 0; s < 8; s++)
            begin
                sv = s[2:0];
                usb2 <= sv;
                usb3 <= sv ^ 3'h5;
                gpio <= ~sv;
                repeat (4) @(posedge pclk);
                @(negedge pclk);
                for (int i = 0; i < 3; i++)
                begin
                    chk("port power", pwr_on[i], pwr_exp(cfg[i], sv[i], sv[i] ^ (i != 1), ~sv[i]));
                    chk("shared pin", comb[i], cfg[i][7]);
                    chk("disabled", dis[i], cfg[i][5]);
                    chk("fixed device", fixed[i], cfg[i][4]);
                end
                @(posedge pclk);
            end
        end
        $display("Test source codes done");
        // Enable low freezes every flop: ports 2 and 3 follow the GPIO, port 4 is disabled
        en <= 1'b0;
        gpio <= 3'h7;
        repeat (5) @(posedge pclk);
        @(negedge pclk);
        chk("power frozen", {29'h0, pwr_on}, 32'h00000000);
        @(posedge pclk);
        en <= 1'b1;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("power after enable", {29'h0, pwr_on}, 32'h00000003);
        @(posedge pclk);
        $display("Test clock enable done");
        // Second reset clears the bank and every output
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("outputs after reset", {20'h0, pwr_on, dis, fixed, comb}, 32'h00000000);
        apb(1'b0, addr[2], 32'h00000000);
        chk("value after reset", rd, 32'h00000000);
        $display("Test second reset done");
        results();
    end
endmodule : tb_port_power_source_select
`default_nettype wire
